/* dv/spfp_assertions.sv */
`timescale 1ns/1ns
module spfp_assertions import spfp_pkg::*; #(
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	// Bus side
	input wire logic        clk_sys_i,
	input wire logic        nrst_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// Link side
	input wire logic        sck_o,
	input wire logic        sck_oe_n_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	// ==========================================================
	// Sequences
	sequence s_wjoin;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_tog;
		!sck_oe_n_o && $changed(sck_o);
	endsequence
	// ==========================================================
	// Properties
	AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer lost");
	AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer lost");
	AST_R_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while busy");
	AST_B_LAT: assert property (s_wjoin |-> ##[2:3] s_axi_bvalid_o)
		else $error("write answer late");
	AST_W_DROP: assert property (s_wjoin |=> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write ready held");
	AST_R_ERR: assert property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR
		|-> s_axi_rdata_o == 32'h0) else $error("error read carries data");
	// Each half period is four system clocks, so a toggle is followed by three still cycles.
	AST_SCK_HALF: assert property (s_tog |=> $stable(sck_o) [*3])
		else $error("serial clock half period wrong");
endmodule // spfp_assertions

/* dv/spfp_partner.sv */
`timescale 1ns/1ns
module spfp_partner #(
	parameter logic [31:0] REP = 32'h0000_0001
) (
	// Link pins
	input  wire logic       sck_i,
	input  wire logic       ss_n_i,
	input  wire logic       sdo_i,
	output logic            sdi_o,
	// Bench side
	input  wire logic [6:0] nb_i,
	output logic [31:0]     rx_o,
	output logic            got_o
);
	logic [31:0] sh = REP;
	logic [31:0] rx = 32'h0;
	int          cnt = 0;
	int          n = 0;
	// Unselected, the line shows the inverse so a stale bit never looks valid.
	assign sdi_o = ss_n_i ? ~sh[31] : sh[31];
	initial got_o = 1'b0;
	// The next reply is staged on the last sampling edge, long before the next char starts.
	always @(posedge sck_i) if (!ss_n_i) begin
		rx = {rx[30:0], sdo_i};
		cnt++;
		if (cnt == nb_i) begin
			rx_o = rx & ~(32'hffff_ffff << nb_i);
			cnt = 0;
			n++;
			sh = REP + n;
			got_o = ~got_o;
		end
	end
	// No shift before the first sample, so both clock idle levels are served.
	always @(negedge sck_i) if (!ss_n_i && cnt != 0) sh = sh << 1;
endmodule // spfp_partner

/* dv/tb_spi_framed_port.sv */
`timescale 1ns/1ns
module tb_spi_framed_port import spfp_pkg::*; ;
	localparam logic [31:0] REP = 32'h5a3c_96e1;
	logic        clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0;
	logic        rry = 1'b0, awr, wrd, bv, arr, rv, sck, sck_oe_n, sso, ss_oe_n;
	logic        sdo, sdo_oe_n, irq, sdi, pgot;
	logic [7:0]  aa = 8'h0, ra = 8'h0;
	logic [31:0] wd = 32'h0, c, dp, d, rdt, prx;
	logic [6:0]  nb = BITS_NARROW;
	logic [1:0]  br, rr;
	logic [67:0] n;
	logic [31:0] sq[$];
	logic [67:0] bq[$];
	integer      seed = 32'hbf3ebf12;
	int          fails = 0, compares = 0, rn = 0, ns, nw;
	wire logic   sck_w = sck_oe_n ? 1'b0 : sck;
	wire logic   ss_w = ss_oe_n ? 1'b1 : sso;
	always #25 clk = ~clk;
	spfp_top u_dut (.clk_sys_i(clk), .nrst_i(nrst),
		.s_axi_awaddr_i(aa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd),
		.s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
		.s_axi_araddr_i(ra), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
		.sck_i(sck_w), .sck_o(sck), .sck_oe_n_o(sck_oe_n), .ss_i(ss_w), .ss_o(sso),
		.ss_oe_n_o(ss_oe_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .irq_o(irq));
	spfp_partner #(.REP(REP)) u_far (.sck_i(sck_w), .ss_n_i(ss_w),
		.sdo_i(sdo_oe_n ? ~sdo : sdo), .sdi_o(sdi), .nb_i(nb), .rx_o(prx), .got_o(pgot));
	// ==========================================================
	// Tasks
	function automatic logic [31:0] lo(input logic [31:0] v);
		return v & ~(32'hffff_ffff << nb);
	endfunction
	task automatic chk_bus(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("Error %0t bus %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_char(input logic [31:0] g, e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("Error %0t char %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = RESP_OKAY);
		bq.push_back({2'b00, r, 64'h0});
		aa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrd) wv <= 1'b0;
		end while (!bv);
		bry <= 1'b1;
		@(posedge clk);
		bry <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
		input logic [1:0] r = RESP_OKAY, input logic ic = 1'b0, iv = 1'b0);
		bq.push_back({ic, iv, r, m, e & m});
		ra <= a;
		arv <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rry <= 1'b1;
		@(posedge clk);
		rry <= 1'b0;
	endtask
	task automatic test_done();
		if (fails == 0 && compares > 0 && sq.size() == 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================================
	// Monitors
	always @(posedge clk) begin
		if (bv && bry) begin
			n = bq.pop_front();
			chk_bus({30'h0, br}, {30'h0, n[65:64]});
		end
		if (rv && rry) begin
			n = bq.pop_front();
			chk_bus(rdt & n[63:32], n[31:0]);
			chk_bus({30'h0, rr}, {30'h0, n[65:64]});
			if (n[67]) chk_bus({31'h0, irq}, {31'h0, n[66]});
		end
	end
	always @(pgot) if ($time > 0) chk_char(prx, sq.pop_front());
	initial begin
		#1_000_000;
		fails++;
		test_done();
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(OFS_CTRL, 32'hffff_ffff, CTRL_RESET);
		rd(8'h20, 32'hffff_ffff, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'h1, RESP_SLVERR);
		wr(OFS_IMASK, 32'h1);
		// Framing stays off, so the edge select is free; the 16-bit pass idles high.
		for (int md = 0; md < 4; md++) begin
			c = 32'h1000_8120 ^ (md == 1 ? 32'h540 : md == 2 ? 32'hc00 : md == 3 ? 32'h800 : 32'h0);
			dp = (md == 3) ? 32'h1_0000 : 32'h0;
			nb = (md == 0) ? BITS_NARROW : (md == 1) ? BITS_HALF : BITS_WIDE;
			nw = (md == 3) ? 5 : 2;
			ns = (md == 3) ? 4 : 2;
			wr(OFS_CTRL, c & ~32'h8000);
			wr(OFS_CTRL, c | dp);
			wr(OFS_CTRL, c);
			rd(OFS_CTRL, 32'hffff_ffff, c | dp);
			for (int k = 0; k < nw; k++) begin
				d = $random(seed);
				if (k < ns) sq.push_back(lo(d));
				wr(OFS_BUF, d);
			end
			rd(OFS_STAT, 32'h2, 32'h2);
			repeat ((8 * nb + 8) * ns) @(posedge clk);
			rd(OFS_STAT, 32'h3, 32'h1, RESP_OKAY, 1'b1, 1'b1);
			for (int k = 0; k < ns - 1; k++) rd(OFS_BUF, lo('1), (REP + rn + k) >> (32 - nb));
			rn += ns;
			rd(OFS_STAT, 32'h1, 32'h0);
			wr(OFS_IMASK, 32'h0);
			rd(OFS_ISTAT, 32'h3, 32'h3, RESP_OKAY, 1'b1, 1'b0);
			wr(OFS_IMASK, 32'h1);
			wr(OFS_ISTAT, 32'h3);
			rd(OFS_ISTAT, 32'h3, 32'h0, RESP_OKAY, 1'b1, 1'b0);
		end
		@(posedge clk);
		test_done();
	end
endmodule // tb_spi_framed_port

bind spfp_top spfp_assertions #(.DEPTH(DEPTH)) u_chk (.clk_sys_i, .nrst_i, .s_axi_awvalid_i,
	.s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
	.s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
	.s_axi_rvalid_o, .s_axi_rready_i, .sck_o, .sck_oe_n_o);

/* verilog/spfp_fifo.sv */
`timescale 1ns/1ns
module spfp_fifo import spfp_pkg::*; #(
	parameter int unsigned DW    = 32,
	parameter int unsigned DEPTH = FIFO_DEPTH,
	parameter int unsigned PW    = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic          clk_sys_i,
	input  wire logic          nrst_i,
	// Mode
	input  wire logic          flush_i,
	input  wire logic          deep_i,
	input  wire logic [PW-1:0] mask_i,
	// Fill side
	input  wire logic          push_valid_i,
	input  wire logic [DW-1:0] push_data_i,
	output logic               push_ready_o,
	// Drain side
	output logic               pop_valid_o,
	output logic [DW-1:0]      pop_data_o,
	input  wire logic          pop_ready_i,
	// Status
	output logic               full_o
);

	if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("spfp_fifo: DEPTH must be a power of two of at least 4");
	end

	logic [DW-1:0] mem [DEPTH];
	logic [PW-1:0] wptr_ff;
	logic [PW-1:0] rptr_ff;
	logic [PW-1:0] wnext;
	logic [PW-1:0] rnext;

	// ==========================================================
	// Pointers
	// Enhanced mode gives up one slot so that full and empty differ by pointers alone.
	assign wnext        = (wptr_ff + 1'b1) & mask_i;
	assign rnext        = (rptr_ff + 1'b1) & mask_i;
	assign full_o       = deep_i ? (wnext == rptr_ff) : (wptr_ff != rptr_ff);
	assign push_ready_o = ~full_o;
	assign pop_valid_o  = wptr_ff != rptr_ff;
	assign pop_data_o   = mem[rptr_ff];

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
		end else if (flush_i) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
		end else begin
			if (push_valid_i && push_ready_o) begin
				wptr_ff <= deep_i ? wnext : wnext & {{(PW-1){1'b0}}, 1'b1};
			end
			if (pop_valid_o && pop_ready_i) begin
				rptr_ff <= deep_i ? rnext : rnext & {{(PW-1){1'b0}}, 1'b1};
			end
		end
	end

	// ==========================================================
	// Storage
	always_ff @(posedge clk_sys_i) begin
		if (push_valid_i && push_ready_o) begin
			mem[wptr_ff] <= push_data_i;
		end
	end

endmodule // spfp_fifo

/* verilog/spfp_pkg.sv */
// Function
// - Frame mode enable turns the slave-select pin into the frame sync signal.
// - Sync direction set waits for an incoming sync; clear drives the sync out.
// - Sync polarity set means active-high sync, clear means active-low.
// - Auto-drive in master role drives select during each character, level from polarity.
// - Sync width set lasts one character, clear lasts one bit clock.
// - Sync count codes 0 to 5 give one pulse per 1 to 32 characters.
// - Sync edge set coincides with first bit clock, clear precedes it by one.
// - Deep FIFO enable selects enhanced buffering and is writable only while off.
// - Characters of 8, 16 or 32 bits with 15, 7 or 3 entry FIFOs in enhanced mode, one entry in standard mode.
// - Master or slave role, four idle-level and data-edge combinations.
// - Standard mode: transmit full sets on buffer write, clears on shifter load.
// - Enhanced mode: transmit full when write pointer plus one equals read pointer.
// - Standard mode: receive full sets on shifter unload, clears on buffer read.
// - Enhanced mode: receive full when write pointer plus one equals read pointer.
// - Each completed character raises an interrupt event, at every width.
package spfp_pkg;

	// ==========================================================
	// Register map
	localparam int unsigned      AXI_AW       = 8;
	localparam logic [7:0]       OFS_CTRL     = 8'h00;
	localparam logic [7:0]       OFS_STAT     = 8'h04;
	localparam logic [7:0]       OFS_BUF      = 8'h08;
	localparam logic [7:0]       OFS_ISTAT    = 8'h0c;
	localparam logic [7:0]       OFS_IMASK    = 8'h10;
	localparam logic [31:0]      CTRL_RESET   = 32'h0000_0000;
	localparam logic [31:0]      CTRL_WMASK   = 32'hff03_bfef;
	localparam int unsigned      STAT_RX_FULL = 0;
	localparam int unsigned      STAT_TX_FULL = 1;
	localparam int unsigned      STAT_RX_AVL  = 2;
	localparam int unsigned      STAT_TX_EMP  = 3;
	localparam int unsigned      STAT_BUSY    = 4;
	localparam int unsigned      IRQ_DONE     = 0;
	localparam int unsigned      IRQ_RX_OVF   = 1;
	localparam int unsigned      IRQ_N        = 2;
	localparam logic [1:0]       IRQ_RESET    = 2'h0;
	localparam logic [1:0]       RESP_OKAY    = 2'h0;
	localparam logic [1:0]       RESP_SLVERR  = 2'h2;

	// ==========================================================
	// Serial engine
	localparam int unsigned      FIFO_DEPTH   = 16;
	localparam logic [7:0]       SCK_HALF_CYC = 8'h04;
	localparam logic [6:0]       BITS_NARROW  = 7'h08;
	localparam logic [6:0]       BITS_HALF    = 7'h10;
	localparam logic [6:0]       BITS_WIDE    = 7'h20;
	localparam logic [2:0]       FRM_CNT_MAX  = 3'h5;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01
	} spfp_state_e;

	typedef enum logic [2:0] {
		SEL_CTRL  = 3'b000,
		SEL_STAT  = 3'b001,
		SEL_BUF   = 3'b010,
		SEL_ISTAT = 3'b011,
		SEL_IMASK = 3'b100,
		SEL_NONE  = 3'b111
	} spfp_sel_e;

	typedef struct packed {
		logic       frame_mode_enable;
		logic       frame_sync_direction;
		logic       frame_sync_polarity;
		logic       master_select_auto_drive;
		logic       frame_sync_width;
		logic [2:0] frame_sync_count;
		logic [5:0] rsv_hi;
		logic       frame_sync_edge;
		logic       deep_fifo_enable;
		logic       module_on;
		logic       rsv_mid;
		logic       idle_stop;
		logic       sdo_disable;
		logic       width_select_wide;
		logic       width_select_half;
		logic       sample_phase;
		logic       clock_edge_select;
		logic       select_enable;
		logic       clock_polarity_select;
		logic       master_role_enable;
		logic       rsv_lo;
		logic [1:0] tx_irq_sel;
		logic [1:0] rx_irq_sel;
	} spfp_ctrl_s;

endpackage

/* verilog/spfp_top.sv */
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
module spfp_top import spfp_pkg::*; #(
	parameter int unsigned DEPTH = FIFO_DEPTH,
	parameter int unsigned PW    = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              nrst_i,
	// AXI4-Lite write
	input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic [1:0]             s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	// AXI4-Lite read
	input  wire logic [AXI_AW-1:0] s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic [31:0]            s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	// Serial clock pin
	input  wire logic              sck_i,
	output logic                   sck_o,
	output logic                   sck_oe_n_o,
	// Slave select and frame sync pin
	input  wire logic              ss_i,
	output logic                   ss_o,
	output logic                   ss_oe_n_o,
	// Data pins
	input  wire logic              sdi_i,
	output logic                   sdo_o,
	output logic                   sdo_oe_n_o,
	// Interrupt
	output logic                   irq_o
);

	if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("spfp_top: DEPTH must be a power of two of at least 4");
	end

	function automatic spfp_sel_e decode(input logic [AXI_AW-1:0] a);
		if (a == OFS_CTRL) begin
			decode = SEL_CTRL;
		end else if (a == OFS_STAT) begin
			decode = SEL_STAT;
		end else if (a == OFS_BUF) begin
			decode = SEL_BUF;
		end else if (a == OFS_ISTAT) begin
			decode = SEL_ISTAT;
		end else if (a == OFS_IMASK) begin
			decode = SEL_IMASK;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	function automatic logic [31:0] lanes(input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			lanes[8*i +: 8] = {8{s[i]}};
		end
	endfunction

	// ==========================================================
	// Pin synchronisers, bit 0 clock, bit 1 select, bit 2 data
	logic [2:0] sync1_ff;
	logic [2:0] sync2_ff;
	logic       sck_prev_ff;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync1_ff    <= 3'h0;
			sync2_ff    <= 3'h0;
			sck_prev_ff <= 1'b0;
		end else begin
			sync1_ff    <= {sdi_i, ss_i, sck_i};
			sync2_ff    <= sync1_ff;
			sck_prev_ff <= sync2_ff[0];
		end
	end

	// ==========================================================
	// Write channels
	logic              aw_hold_ff;
	logic              w_hold_ff;
	logic              awready_ff;
	logic              wready_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic [AXI_AW-1:0] awaddr_ff;
	logic [31:0]       wdata_ff;
	logic [3:0]        wstrb_ff;
	logic              aw_fire;
	logic              w_fire;
	logic              wr_do;
	logic              nxt_aw_hold;
	logic              nxt_w_hold;
	spfp_sel_e         wr_sel;
	logic [31:0]       wr_bits;
	logic [31:0]       wr_keep;

	assign aw_fire     = s_axi_awvalid_i & awready_ff;
	assign w_fire      = s_axi_wvalid_i & wready_ff;
	assign wr_do       = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	assign nxt_aw_hold = (aw_hold_ff | aw_fire) & ~wr_do;
	assign nxt_w_hold  = (w_hold_ff | w_fire) & ~wr_do;
	assign wr_sel      = decode(awaddr_ff);
	assign wr_bits     = wdata_ff & lanes(wstrb_ff);
	assign wr_keep     = ~lanes(wstrb_ff);

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= RESP_OKAY;
			awaddr_ff  <= '0;
			wdata_ff   <= 32'h0;
			wstrb_ff   <= 4'h0;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			awready_ff <= ~nxt_aw_hold;
			wready_ff  <= ~nxt_w_hold;
			if (aw_fire) begin
				awaddr_ff <= s_axi_awaddr_i;
			end
			if (w_fire) begin
				wdata_ff <= s_axi_wdata_i;
				wstrb_ff <= s_axi_wstrb_i;
			end
			if (wr_do) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready_i) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Control register
	spfp_ctrl_s  ctrl_ff;
	logic [31:0] nxt_ctrl;

	always_comb begin
		nxt_ctrl = ((ctrl_ff & wr_keep) | wr_bits) & CTRL_WMASK;
		if (ctrl_ff.module_on) begin
			nxt_ctrl[16] = ctrl_ff.deep_fifo_enable;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_ff <= CTRL_RESET;
		end else if (wr_do && wr_sel == SEL_CTRL) begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// ==========================================================
	// Character format
	logic [6:0]    nbits;
	logic [31:0]   wmask;
	logic [PW-1:0] dmask;
	logic [2:0]    frm_code;
	logic [5:0]    frm_span;
	logic [4:0]    frm_mask;

	always_comb begin
		if (ctrl_ff.width_select_wide) begin
			nbits = BITS_WIDE;
			wmask = 32'hffff_ffff;
			dmask = PW'(DEPTH / 4 - 1);
		end else if (ctrl_ff.width_select_half) begin
			nbits = BITS_HALF;
			wmask = 32'h0000_ffff;
			dmask = PW'(DEPTH / 2 - 1);
		end else begin
			nbits = BITS_NARROW;
			wmask = 32'h0000_00ff;
			dmask = PW'(DEPTH - 1);
		end
	end

	// Reserved count codes fall back to a pulse on every character.
	assign frm_code = (ctrl_ff.frame_sync_count > FRM_CNT_MAX) ? 3'h0 : ctrl_ff.frame_sync_count;
	assign frm_span = 6'h01 << frm_code;
	assign frm_mask = 5'(frm_span - 6'h01);

	// ==========================================================
	// FIFOs, flushed while the module is off
	logic        tx_push_rdy;
	logic        tx_avail;
	logic [31:0] tx_data;
	logic        tx_pop;
	logic        tx_full;
	logic        rx_push;
	logic        rx_push_rdy;
	logic        rx_avail;
	logic [31:0] rx_data;
	logic        rx_pop;
	logic        rx_full;
	logic [31:0] nxt_rx_sh;
	logic        ar_fire;
	spfp_sel_e   rd_sel;

	assign rd_sel  = decode(s_axi_araddr_i);
	assign rx_pop  = ar_fire & (rd_sel == SEL_BUF);

	spfp_fifo #(.DW(32), .DEPTH(DEPTH), .PW(PW)) u_tx_fifo (
		.clk_sys_i    (clk_sys_i),
		.nrst_i       (nrst_i),
		.flush_i      (~ctrl_ff.module_on),
		.deep_i       (ctrl_ff.deep_fifo_enable),
		.mask_i       (dmask),
		.push_valid_i (wr_do & (wr_sel == SEL_BUF)),
		.push_data_i  (wdata_ff),
		.push_ready_o (tx_push_rdy),
		.pop_valid_o  (tx_avail),
		.pop_data_o   (tx_data),
		.pop_ready_i  (tx_pop),
		.full_o       (tx_full)
	);

	spfp_fifo #(.DW(32), .DEPTH(DEPTH), .PW(PW)) u_rx_fifo (
		.clk_sys_i    (clk_sys_i),
		.nrst_i       (nrst_i),
		.flush_i      (~ctrl_ff.module_on),
		.deep_i       (ctrl_ff.deep_fifo_enable),
		.mask_i       (dmask),
		.push_valid_i (rx_push),
		.push_data_i  (nxt_rx_sh & wmask),
		.push_ready_o (rx_push_rdy),
		.pop_valid_o  (rx_avail),
		.pop_data_o   (rx_data),
		.pop_ready_i  (rx_pop),
		.full_o       (rx_full)
	);

	// ==========================================================
	// Serial engine
	spfp_state_e state_ff;
	logic [31:0] tx_sh_ff;
	logic [31:0] rx_sh_ff;
	logic [7:0]  half_ff;
	logic [7:0]  div_ff;
	logic        sck_pin_ff;
	logic        sync_on_ff;
	logic        pre_ff;
	logic [4:0]  frm_cnt_ff;
	logic        run;
	logic        framed;
	logic        cke_eff;
	logic        drive_sync;
	logic        sync_in_act;
	logic        slave_sel;
	logic        start;
	logic        tick;
	logic        lead;
	logic [7:0]  pre2;
	logic        in_pre;
	logic        sample;
	logic        shift;
	logic        last;

	assign run         = state_ff == ST_RUN;
	assign framed      = ctrl_ff.frame_mode_enable;
	// The edge select has no meaning in framed mode and is forced to zero there.
	assign cke_eff     = ctrl_ff.clock_edge_select & ~framed;
	assign drive_sync  = framed & ~ctrl_ff.frame_sync_direction;
	assign sync_in_act = sync2_ff[1] == ctrl_ff.frame_sync_polarity;
	assign slave_sel   = framed | ~ctrl_ff.select_enable | ~sync2_ff[1];
	assign start       = ctrl_ff.module_on
		& (ctrl_ff.master_role_enable ? tx_avail : slave_sel)
		& (~(framed & ctrl_ff.frame_sync_direction & (frm_cnt_ff == 5'h00)) | sync_in_act);
	assign tick        = run & (ctrl_ff.master_role_enable ? (div_ff == SCK_HALF_CYC - 8'h01)
		: (sync2_ff[0] ^ sck_prev_ff));
	assign lead        = ~half_ff[0];
	assign pre2        = {6'h00, pre_ff, 1'b0};
	assign in_pre      = half_ff < pre2;
	assign sample      = tick & ~in_pre & (cke_eff ? lead : ~lead);
	assign shift       = tick & ~in_pre & (cke_eff ? ~lead : (lead & (half_ff != pre2)));
	assign last        = tick & (half_ff == 8'({nbits, 1'b0}) + pre2 - 8'h01);
	assign nxt_rx_sh   = sample ? {rx_sh_ff[30:0], sync2_ff[2]} : rx_sh_ff;
	assign rx_push     = last;
	assign tx_pop      = ~run & start & tx_avail;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_ff   <= ST_IDLE;
			tx_sh_ff   <= 32'h0;
			rx_sh_ff   <= 32'h0;
			half_ff    <= 8'h00;
			div_ff     <= 8'h00;
			sync_on_ff <= 1'b0;
			pre_ff     <= 1'b0;
			frm_cnt_ff <= 5'h00;
		end else if (!ctrl_ff.module_on) begin
			state_ff   <= ST_IDLE;
			half_ff    <= 8'h00;
			frm_cnt_ff <= 5'h00;
		end else if (!run) begin
			if (start) begin
				state_ff   <= ST_RUN;
				tx_sh_ff   <= tx_avail ? tx_data << (6'(7'h20 - nbits)) : 32'h0;
				half_ff    <= 8'h00;
				div_ff     <= 8'h00;
				sync_on_ff <= framed & (frm_cnt_ff == 5'h00);
				pre_ff     <= framed & (frm_cnt_ff == 5'h00) & ~ctrl_ff.frame_sync_edge;
			end
		end else if (!ctrl_ff.master_role_enable && !slave_sel) begin
			state_ff <= ST_IDLE;
			half_ff  <= 8'h00;
		end else begin
			div_ff   <= (div_ff == SCK_HALF_CYC - 8'h01) ? 8'h00 : div_ff + 8'h01;
			rx_sh_ff <= nxt_rx_sh;
			if (shift) begin
				tx_sh_ff <= {tx_sh_ff[30:0], 1'b0};
			end
			if (tick) begin
				half_ff <= half_ff + 8'h01;
			end
			if (last) begin
				state_ff   <= ST_IDLE;
				frm_cnt_ff <= (frm_cnt_ff + 5'h01) & frm_mask;
			end
		end
	end

	// ==========================================================
	// Pin drivers
	logic ss_o_ff;
	logic ss_oe_n_ff;
	logic sck_oe_n_ff;
	logic sdo_oe_n_ff;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sck_pin_ff  <= 1'b0;
			sck_oe_n_ff <= 1'b1;
			ss_o_ff     <= 1'b1;
			ss_oe_n_ff  <= 1'b1;
			sdo_oe_n_ff <= 1'b1;
		end else begin
			if (!run || !ctrl_ff.master_role_enable) begin
				sck_pin_ff <= ctrl_ff.clock_polarity_select;
			end else if (tick) begin
				sck_pin_ff <= ~sck_pin_ff;
			end
			sck_oe_n_ff <= ~(ctrl_ff.module_on & ctrl_ff.master_role_enable);
			sdo_oe_n_ff <= ~(ctrl_ff.module_on & ~ctrl_ff.sdo_disable);
			if (drive_sync) begin
				ss_o_ff <= ctrl_ff.frame_sync_polarity ^ ~(run & sync_on_ff
					& (ctrl_ff.frame_sync_width | (half_ff < 8'h02)));
			end else begin
				ss_o_ff <= ctrl_ff.frame_sync_polarity ^ ~run;
			end
			ss_oe_n_ff <= ~(ctrl_ff.module_on & (drive_sync | (ctrl_ff.master_role_enable
				& ~framed & ctrl_ff.master_select_auto_drive)));
		end
	end

	// ==========================================================
	// Interrupts
	logic [IRQ_N-1:0] istat_ff;
	logic [IRQ_N-1:0] imask_ff;
	logic [IRQ_N-1:0] ievent;
	logic [IRQ_N-1:0] iclr;
	logic [IRQ_N-1:0] nxt_istat;
	logic             irq_ff;

	assign ievent[IRQ_DONE]   = last;
	assign ievent[IRQ_RX_OVF] = last & ~rx_push_rdy;
	assign iclr               = (wr_do && wr_sel == SEL_ISTAT) ? wr_bits[IRQ_N-1:0] : '0;
	// A new event in the clearing cycle survives the clear.
	assign nxt_istat          = (istat_ff & ~iclr) | ievent;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			istat_ff <= IRQ_RESET;
			imask_ff <= IRQ_RESET;
			irq_ff   <= 1'b0;
		end else begin
			istat_ff <= nxt_istat;
			if (wr_do && wr_sel == SEL_IMASK) begin
				imask_ff <= ((imask_ff & wr_keep[IRQ_N-1:0]) | wr_bits[IRQ_N-1:0]);
			end
			irq_ff <= |(nxt_istat & imask_ff);
		end
	end

	// ==========================================================
	// Read channel
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rd_word;

	assign ar_fire = s_axi_arvalid_i & arready_ff;

	always_comb begin
		rd_word = 32'h0;
		if (rd_sel == SEL_CTRL) begin
			rd_word = ctrl_ff;
		end else if (rd_sel == SEL_STAT) begin
			rd_word[STAT_RX_FULL] = rx_full;
			rd_word[STAT_TX_FULL] = tx_full;
			rd_word[STAT_RX_AVL]  = rx_avail;
			rd_word[STAT_TX_EMP]  = ~tx_avail;
			rd_word[STAT_BUSY]    = run;
		end else if (rd_sel == SEL_BUF) begin
			rd_word = rx_data;
		end else if (rd_sel == SEL_ISTAT) begin
			rd_word[IRQ_N-1:0] = istat_ff;
		end else if (rd_sel == SEL_IMASK) begin
			rd_word[IRQ_N-1:0] = imask_ff;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0;
			rresp_ff   <= RESP_OKAY;
		end else if (ar_fire) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= rd_word;
			rresp_ff   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (!rvalid_ff || s_axi_rready_i) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready_o = awready_ff;
	assign s_axi_wready_o  = wready_ff;
	assign s_axi_bvalid_o  = bvalid_ff;
	assign s_axi_bresp_o   = bresp_ff;
	assign s_axi_arready_o = arready_ff;
	assign s_axi_rvalid_o  = rvalid_ff;
	assign s_axi_rdata_o   = rdata_ff;
	assign s_axi_rresp_o   = rresp_ff;
	assign sck_o           = sck_pin_ff;
	assign sck_oe_n_o      = sck_oe_n_ff;
	assign ss_o            = ss_o_ff;
	assign ss_oe_n_o       = ss_oe_n_ff;
	assign sdo_o           = tx_sh_ff[31];
	assign sdo_oe_n_o      = sdo_oe_n_ff;
	assign irq_o           = irq_ff;

endmodule // spfp_top
